// >>> hdl/pmic_i2c_defs.svh
`ifndef PMIC_I2C_DEFS_SVH
`define PMIC_I2C_DEFS_SVH

// ==========================================================================
// Target address reset values, replaced by the configuration load
`define SLV_ADDR0_RST 7'h5E
`define SLV_ADDR1_RST 7'h6E

// ==========================================================================
// Byte framing
`define BYTE_LAST_BIT 3'h7
`define BIT_MSB 7
`define DIR_READ 1'b1

// ==========================================================================
// Register space: partition select above an 8-bit offset
`define MEM_WORDS 512

`endif

// >>> hdl/pmic_i2c_pkg.sv
`default_nettype none

package pmic_i2c_pkg;

	// ======================================================================
	// Link engine states
	typedef enum logic [8:0]
	{
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_OFFS = 9'h008,
		ST_OACK = 9'h010,
		ST_DATA = 9'h020,
		ST_DACK = 9'h040,
		ST_READ = 9'h080,
		ST_RACK = 9'h100
	} link_state_e;

	// ======================================================================
	// Register space types
	typedef logic [8:0] mem_addr_t;
	typedef logic [7:0] byte_t;

endpackage

`default_nettype wire

// >>> hdl/reg_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface reg_mem_if
	import pmic_i2c_pkg::*;
	();

	logic wr_en;
	mem_addr_t addr;
	byte_t wdata;
	byte_t rdata;

	modport ctrl
	(
		output wr_en,
		output addr,
		output wdata,
		input rdata
	);

	modport mem
	(
		input wr_en,
		input addr,
		input wdata,
		output rdata
	);

endinterface

`default_nettype wire

// >>> hdl/reg_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmic_i2c_defs.svh"

module reg_mem
	import pmic_i2c_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Access port
	reg_mem_if.mem mem_port
);

	// ======================================================================
	// Storage, both partitions side by side
	byte_t store [0:`MEM_WORDS-1];
	byte_t rdata_reg;
	byte_t rdata_next;

	always_comb
	begin
		rdata_next = store[mem_port.addr];
	end

	// No reset on the array: contents come only from link writes
	always_ff @(posedge clk_sys)
	begin
		if (mem_port.wr_en)
		begin
			store[mem_port.addr] <= mem_port.wdata;
		end
		rdata_reg <= rdata_next;
	end

	assign mem_port.rdata = rdata_reg;

endmodule

`default_nettype wire

// >>> hdl/pmic_i2c_register_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmic_i2c_defs.svh"

module pmic_i2c_register_slave
	import pmic_i2c_pkg::*;
(
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial link, clock pin is also the link clock
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Address configuration
	input wire logic [6:0] otp_addr0,
	input wire logic [6:0] otp_addr1,
	input wire logic otp_load,
	output logic addr_locked,
	// Write notification to the rest of the chip
	output logic reg_wr_pulse,
	output logic [8:0] reg_wr_addr,
	output logic [7:0] reg_wr_data
);

	// ======================================================================
	// Link clock domain: capture each bit on the rising clock edge
	logic bit_cap_reg;
	logic bit_cap_next;
	logic tgl_reg;
	logic tgl_next;

	always_comb
	begin
		bit_cap_next = sda_i;
		tgl_next = ~tgl_reg;
	end

	// Clock may stand still while idle, so clear without waiting for an edge
	always_ff @(posedge scl_clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cap_reg <= 1'b0;
			tgl_reg <= 1'b0;
		end
		else
		begin
			bit_cap_reg <= bit_cap_next;
			tgl_reg <= tgl_next;
		end
	end

	// ======================================================================
	// Crossing: toggle event plus level copies of both pins
	// Index 0 toggle, 1 clock pin, 2 data pin
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] s1_next;
	logic [2:0] s2_next;
	logic [2:0] s3_next;

	always_comb
	begin
		s1_next = {sda_i, scl_clk, tgl_reg};
		s2_next = s1_reg;
		s3_next = s2_reg;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			// Pins idle high, toggle copy matches its own reset: no false event
			s1_reg <= 3'h6;
			s2_reg <= 3'h6;
			s3_reg <= 3'h6;
		end
		else
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
		end
	end

	// Captured bit is stable for a whole clock period after the toggle
	logic bit_evt;
	logic fall_det;
	logic start_det;
	logic stop_det;

	assign bit_evt = s2_reg[0] ^ s3_reg[0];
	assign fall_det = ~s2_reg[1] & s3_reg[1];
	assign start_det = s2_reg[1] & s3_reg[1] & ~s2_reg[2] & s3_reg[2];
	assign stop_det = s2_reg[1] & s3_reg[1] & s2_reg[2] & ~s3_reg[2];

	// ======================================================================
	// Address configuration and lock
	logic [6:0] addr0_reg;
	logic [6:0] addr1_reg;
	logic lock_reg;
	logic [6:0] addr0_next;
	logic [6:0] addr1_next;
	logic lock_next;

	always_comb
	begin
		addr0_next = addr0_reg;
		addr1_next = addr1_reg;
		lock_next = lock_reg;
		if (otp_load && !lock_reg)
		begin
			addr0_next = otp_addr0;
			addr1_next = otp_addr1;
			lock_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			addr0_reg <= `SLV_ADDR0_RST;
			addr1_reg <= `SLV_ADDR1_RST;
			lock_reg <= 1'b0;
		end
		else
		begin
			addr0_reg <= addr0_next;
			addr1_reg <= addr1_next;
			lock_reg <= lock_next;
		end
	end

	// Returns {hit on second address, hit on first address}
	function automatic logic [1:0] addr_hit(input logic [6:0] a, input logic [6:0] a0,
		input logic [6:0] a1);
		addr_hit = {a == a1, a == a0};
	endfunction

	// ======================================================================
	// Link engine
	reg_mem_if mem_bus();

	link_state_e state_reg;
	link_state_e state_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	byte_t sh_reg;
	byte_t sh_next;
	byte_t offs_reg;
	byte_t offs_next;
	logic part_reg;
	logic part_next;
	logic rw_reg;
	logic rw_next;
	logic ackon_reg;
	logic ackon_next;
	logic oe_reg;
	logic oe_next;
	logic wr_reg;
	logic wr_next;
	logic [1:0] hit;
	logic [7:0] rx_byte;

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		offs_next = offs_reg;
		part_next = part_reg;
		rw_next = rw_reg;
		ackon_next = ackon_reg;
		oe_next = oe_reg;
		wr_next = 1'b0;
		rx_byte = {sh_reg[6:0], bit_cap_reg};
		hit = addr_hit(sh_reg[6:0], addr0_reg, addr1_reg);
		if (stop_det)
		begin
			state_next = ST_IDLE;
			oe_next = 1'b0;
			ackon_next = 1'b0;
		end
		else if (start_det)
		begin
			// Repeated START keeps the stored offset for the read
			state_next = ST_ADDR;
			cnt_next = 3'h0;
			oe_next = 1'b0;
			ackon_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					oe_next = 1'b0;
				end
				ST_ADDR, ST_OFFS, ST_DATA:
				begin
					// Pace set purely by the master's clock edges
					if (bit_evt)
					begin
						sh_next = rx_byte;
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `BYTE_LAST_BIT)
						begin
							if (state_reg == ST_ADDR)
							begin
								if (hit != 2'b00)
								begin
									part_next = hit[1];
									rw_next = bit_cap_reg;
									state_next = ST_AACK;
								end
								else
								begin
									state_next = ST_IDLE;
								end
							end
							else if (state_reg == ST_OFFS)
							begin
								offs_next = rx_byte;
								state_next = ST_OACK;
							end
							else
							begin
								state_next = ST_DACK;
							end
						end
					end
				end
				ST_AACK, ST_OACK, ST_DACK:
				begin
					if (fall_det && !ackon_reg)
					begin
						oe_next = 1'b1;
						ackon_next = 1'b1;
						wr_next = (state_reg == ST_DACK);
					end
					else if (fall_det)
					begin
						ackon_next = 1'b0;
						oe_next = 1'b0;
						cnt_next = 3'h0;
						if (state_reg == ST_AACK && rw_reg == `DIR_READ)
						begin
							sh_next = mem_bus.rdata;
							oe_next = ~mem_bus.rdata[`BIT_MSB];
							state_next = ST_READ;
						end
						else if (state_reg == ST_AACK)
						begin
							state_next = ST_OFFS;
						end
						else if (state_reg == ST_OACK)
						begin
							state_next = ST_DATA;
						end
						else
						begin
							// Extra bytes get no ack: one offset only
							state_next = ST_IDLE;
						end
					end
				end
				ST_READ:
				begin
					if (bit_evt)
					begin
						sh_next = {sh_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `BYTE_LAST_BIT)
						begin
							state_next = ST_RACK;
						end
					end
					else if (fall_det)
					begin
						oe_next = ~sh_reg[`BIT_MSB];
					end
				end
				ST_RACK:
				begin
					if (fall_det)
					begin
						oe_next = 1'b0;
					end
					if (bit_evt)
					begin
						// Single byte per read, whatever the master answers
						state_next = ST_IDLE;
					end
				end
				default:
				begin
					state_next = ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			offs_reg <= 8'h00;
			part_reg <= 1'b0;
			rw_reg <= 1'b0;
			ackon_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			offs_reg <= offs_next;
			part_reg <= part_next;
			rw_reg <= rw_next;
			ackon_reg <= ackon_next;
			oe_reg <= oe_next;
			wr_reg <= wr_next;
		end
	end

	// ======================================================================
	// Register space
	assign mem_bus.wr_en = wr_reg;
	assign mem_bus.addr = {part_reg, offs_reg};
	assign mem_bus.wdata = sh_reg;

	reg_mem u_mem
	(
		.clk_sys(clk_sys),
		.mem_port(mem_bus.mem)
	);

	// ======================================================================
	// Outputs; data line only ever pulled low, clock line never driven
	assign sda_o = 1'b0;
	assign sda_oe = oe_reg;
	assign addr_locked = lock_reg;
	assign reg_wr_pulse = wr_reg;
	assign reg_wr_addr = {part_reg, offs_reg};
	assign reg_wr_data = sh_reg;

endmodule

`default_nettype wire

// >>> dv/pmic_i2c_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pmic_i2c_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link
	input wire logic scl_clk,
	input wire logic sda_o,
	input wire logic sda_oe,
	// Configuration and writes
	input wire logic otp_load,
	input wire logic addr_locked,
	input wire logic reg_wr_pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ====
	// Address configuration
	a_lock_on_load: assert property (otp_load && !addr_locked |=> addr_locked)
		else $error("no lock after load");
	a_lock_cause: assert property (!addr_locked && !otp_load |=> !addr_locked)
		else $error("lock without load");
	a_lock_stays: assert property (addr_locked |=> addr_locked)
		else $error("lock dropped");

	// ====
	// Register writes
	a_pulse_single: assert property (reg_wr_pulse |=> !reg_wr_pulse [*8])
		else $error("write pulse repeated");
	a_commit_in_ack: assert property (reg_wr_pulse |-> sda_oe)
		else $error("write outside ack");

	// ====
	// Pin behaviour: open drain, SDA moves only while SCL is low
	a_drive_low_only: assert property (sda_o == 1'b0)
		else $error("sda driven high");
	a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_clk)
		else $error("sda pulled with scl high");
	a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_clk)
		else $error("sda freed with scl high");

	cover property (reg_wr_pulse);
	cover property ($rose(addr_locked));
	cover property ($fell(sda_oe));
endmodule

`default_nettype wire

// >>> dv/i2c_host.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_host
	import pmic_i2c_pkg::*;
(
	// Bus lines
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	logic tk = 1'b0;

	initial
		forever #15 tk = ~tk;
	initial
	begin
		scl <= 1'b1;
		sda_oe <= 1'b0;
	end

	// ====
	// Bit timing: 150 ns halves, near the top rate
	task automatic hp;
		repeat (5) @(posedge tk);
	endtask

	task automatic start;
		@(posedge tk);
		sda_oe <= 1'b0;
		hp;
		scl <= 1'b1;
		hp;
		sda_oe <= 1'b1;
		hp;
		scl <= 1'b0;
	endtask

	task automatic stop;
		@(posedge tk);
		sda_oe <= 1'b1;
		hp;
		scl <= 1'b1;
		hp;
		sda_oe <= 1'b0;
		hp;
	endtask

	// SDA changes one tick after the fall, never with SCL high
	task automatic bit_x(input logic b, output logic r);
		@(posedge tk);
		sda_oe <= ~b;
		repeat (4) @(posedge tk);
		scl <= 1'b1;
		hp;
		r = sda;
		scl <= 1'b0;
	endtask

	task automatic xfer(input byte_t d, output byte_t q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(1'b1, k);
	endtask

	// ====
	// Transactions, one offset each
	task automatic wr(input logic [6:0] a, input byte_t o, d, input logic x,
		output logic [3:0] k);
		byte_t q;
		k = 4'hF;
		start;
		xfer({a, 1'b0}, q, k[3]);
		xfer(o, q, k[2]);
		xfer(d, q, k[1]);
		if (x)
			xfer(8'h5A, q, k[0]);
		stop;
	endtask

	task automatic rd(input logic [6:0] a, input byte_t o, output byte_t q,
		output logic [3:0] k);
		start;
		xfer({a, 1'b0}, q, k[3]);
		xfer(o, q, k[2]);
		start;
		xfer({a, 1'b1}, q, k[1]);
		xfer(8'hFF, q, k[0]);
		stop;
	endtask
endmodule

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
	import pmic_i2c_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic otp_load = 1'b0;
	logic [6:0] otp_addr0 = 7'h00;
	logic [6:0] otp_addr1 = 7'h00;
	logic scl_clk, sda_i, sda_o, sda_oe, m_oe, addr_locked, reg_wr_pulse;
	logic [8:0] reg_wr_addr, wa;
	byte_t reg_wr_data, wd;
	logic [15:0] n_wr = 16'h0000;
	int miscompares = 0;
	int samples_checked = 0;

	// Wired-AND with pull-up
	assign sda_i = !m_oe && (sda_oe ? sda_o : 1'b1);

	pmic_i2c_register_slave i_pmic_i2c_register_slave
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.scl_clk(scl_clk),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.otp_addr0(otp_addr0),
		.otp_addr1(otp_addr1),
		.otp_load(otp_load),
		.addr_locked(addr_locked),
		.reg_wr_pulse(reg_wr_pulse),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data)
	);
	i2c_host i_i2c_host
	(
		.scl(scl_clk),
		.sda_oe(m_oe),
		.sda(sda_i)
	);

	initial
		forever #2 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
		if (reg_wr_pulse)
		begin
			n_wr <= n_wr + 16'h0001;
			wa <= reg_wr_addr;
			wd <= reg_wr_data;
		end

	// ====
	// Shared tasks
	task automatic chk(input logic [15:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	// ====
	// Scenarios
	task automatic t_write_read;
		logic [3:0] k;
		byte_t q;
		i_i2c_host.wr(7'h5E, 8'h12, 8'hA5, 1'b0, k);
		chk(k, 4'h1);
		chk(wa, 9'h012);
		chk(wd, 8'hA5);
		i_i2c_host.wr(7'h6E, 8'h12, 8'h3C, 1'b0, k);
		chk(wa, 9'h112);
		i_i2c_host.rd(7'h5E, 8'h12, q, k);
		chk(k, 4'h1);
		chk(q, 8'hA5);
		i_i2c_host.rd(7'h6E, 8'h12, q, k);
		chk(q, 8'h3C);
		$display("test write_read done");
	endtask

	task automatic t_refuse;
		logic [3:0] k;
		logic [15:0] n;
		n = n_wr;
		i_i2c_host.wr(7'h5F, 8'h12, 8'h00, 1'b0, k);
		chk(k, 4'hF);
		i_i2c_host.wr(7'h78, 8'h12, 8'h00, 1'b0, k);
		chk(k, 4'hF);
		i_i2c_host.wr(7'h5E, 8'h34, 8'h69, 1'b1, k);
		chk(k, 4'h1);
		chk(n_wr - n, 16'h0001);
		chk(wd, 8'h69);
		$display("test refuse done");
	endtask

	task automatic t_otp_lock;
		logic [3:0] k;
		byte_t q;
		@(posedge clk_sys);
		otp_addr0 <= 7'h21;
		otp_addr1 <= 7'h32;
		otp_load <= 1'b1;
		@(posedge clk_sys);
		otp_addr0 <= 7'h5E;
		otp_addr1 <= 7'h6E;
		@(posedge clk_sys);
		otp_load <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(addr_locked, 1'b1);
		i_i2c_host.wr(7'h5E, 8'h07, 8'h00, 1'b0, k);
		chk(k, 4'hF);
		i_i2c_host.wr(7'h32, 8'h07, 8'hC3, 1'b0, k);
		chk(k, 4'h1);
		chk(wa, 9'h107);
		i_i2c_host.rd(7'h32, 8'h07, q, k);
		chk(q, 8'hC3);
		do_reset;
		chk(addr_locked, 1'b0);
		i_i2c_host.wr(7'h5E, 8'h07, 8'h81, 1'b0, k);
		chk(k, 4'h1);
		chk(wa, 9'h007);
		chk(wd, 8'h81);
		$display("test otp_lock done");
	endtask

	initial
	begin
		do_reset;
		t_write_read;
		t_refuse;
		t_otp_lock;
		stop_test;
	end

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		stop_test;
	end
endmodule

bind pmic_i2c_register_slave pmic_i2c_chk i_pmic_i2c_chk
(
	.clk_sys(clk_sys),
	.rst(rst),
	.scl_clk(scl_clk),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.otp_load(otp_load),
	.addr_locked(addr_locked),
	.reg_wr_pulse(reg_wr_pulse)
);

`default_nettype wire
